// ---- hw/rsh_params.svh ----
/*
  Offsets, field positions, reset values and fixed codes of the remote
  station handshake block. Assumes inclusion by its bare name.
*/
// What this block does
// [RULE1] Completion flag rises when posted command finishes
// [RULE2] Completion flag drops when command request drops
// [RULE3] Master drops request only after seeing completion
// [RULE4] Initial-setting complete rises after initial processing
// [RULE5] Initial-setting complete drops with its request
// [RULE6] Error flag set on error, cleared by reset request
// [RULE7] Monitor request returns registered system words
// [RULE8] Periodic write request keeps writing registered words
// [RULE9] Remote ready while started and online
// [RULE10] Write to system word 13 sets touch-complete
// [RULE11] Touch-complete also raises tag-code read request
// [RULE12] Continuous read of word 13 clears touch flags
// [RULE13] Tag code delivered as 8-bit code
// [RULE14] Master outgoing words appear at link +36..+51
// [RULE15] Link words +20..+35 copied to master incoming
// [RULE16] Register base steps by 4 per station
// [RULE17] First response word holds error code only on error
// [RULE18] Remote ready clear offline or during initial entry
// [RULE19] Device flags deasserted after reset
`ifndef RSH_PARAMS_SVH
`define RSH_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RSH_OFF_CTRL      12'h000
`define RSH_OFF_ACTION    12'h004
`define RSH_OFF_STATUS    12'h008
`define RSH_OFF_IRQ_STAT  12'h00c
`define RSH_OFF_IRQ_MASK  12'h010
`define RSH_OFF_BASE      12'h014
`define RSH_OFF_LINK_IN   12'h040
`define RSH_OFF_LINK_OUT  12'h080
`define RSH_OFF_RESP      12'h0c0
`define RSH_OFF_SYSDATA   12'h100
`define RSH_OFF_MAP       12'h140
`define RSH_WIN_SPAN      12'h040

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSH_CTRL_OS       0
`define RSH_CTRL_ONLINE   1
`define RSH_CTRL_INIT     2
`define RSH_CTRL_CMDMODE  3
`define RSH_CTRL_PWC_LO   4
`define RSH_CTRL_PWC_HI   8
`define RSH_ACT_CMD_FIN   0
`define RSH_ACT_INIT_FIN  1
`define RSH_ACT_ERR       2
`define RSH_ACT_CODE_LO   16
`define RSH_ACT_CODE_HI   31
`define RSH_MAP_MON_LO    0
`define RSH_MAP_MON_HI    3
`define RSH_MAP_PW_LO     8
`define RSH_MAP_PW_HI     11
`define RSH_STAT_RX_LO    8

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define RSH_EV_CMD_REQ    0
`define RSH_EV_INIT_REQ   1
`define RSH_EV_ERR_RST    2
`define RSH_EV_MON_REQ    3
`define RSH_EV_TOUCH_CLR  4
`define RSH_EV_W          5

// ----------------------------------------------------------------
// Fixed codes and reset values
// ----------------------------------------------------------------
`define RSH_CMD_CONT_READ 8'h02
`define RSH_TOUCH_WORD    4'hd
`define RSH_BASE_STEP     12'h004
`define RSH_RD_BASE       12'h100
`define RSH_CTRL_RST      32'h0000_0000
`define RSH_MASK_RST      5'h00

`endif

// ---- hw/rsh_pkg.sv ----
/*
  Types shared by the remote station handshake block.
  Assumes nothing of its surroundings.
*/
package rsh_pkg;
  // Flags from the master station
  typedef struct packed {
    logic err_rst;                 // Error reset request
    logic init_req;                // Initial data setting request
    logic pwr_req;                 // Periodic write request
    logic mon_req;                 // Monitor request
    logic cmd_req;                 // Command request
  } rsh_ry_type;

  // Flags toward the master station
  typedef struct packed {
    logic ready;                   // Remote ready
    logic err;                     // Error condition
    logic init_done;               // Initial setting complete
    logic tag_req;                 // Tag code read request
    logic touch_done;              // Touch complete
    logic cmd_done;                // Command complete
  } rsh_rx_type;

  typedef logic [15:0][15:0] rsh_words_type;  // Sixteen remote words
endpackage

// ---- hw/rsh_top.sv ----
/*
  Remote station handshake: flag pairs toward the master, remote word
  windows, touch tag delivery and an APB register file for firmware.
  Assumes master flags and words synchronous to pclk, one APB master.
*/
`timescale 1ns/100ps
`include "rsh_params.svh"

module rsh_top #(
  parameter int NWORDS = 16        // Remote words per direction
) (
  input  wire logic               pclk,       // Bus and block clock
  input  wire logic               presetn,    // Async reset, active low
  input  wire logic               psel,       // APB select
  input  wire logic               penable,    // APB access phase
  input  wire logic               pwrite,     // APB write
  input  wire logic [11:0]        paddr,      // APB byte address
  input  wire logic [31:0]        pwdata,     // APB write data
  input  wire logic [3:0]         pstrb,      // APB byte strobes
  output logic      [31:0]        prdata,     // APB read data
  output logic                    pready,     // APB ready
  output logic                    pslverr,    // APB error
  input  wire rsh_pkg::rsh_ry_type    ry,         // Flags from master
  input  wire rsh_pkg::rsh_words_type rww,        // Words from master
  input  wire logic [5:0]         station,    // Station number
  output rsh_pkg::rsh_rx_type         rx,         // Flags to master
  output rsh_pkg::rsh_words_type      rwr,        // Words to master
  output logic      [7:0]         tag_code,   // Touch tag code
  output logic      [11:0]        wr_base,    // Outgoing word base
  output logic      [11:0]        rd_base,    // Incoming word base
  output logic                    irq         // Interrupt, active high
);
  import rsh_pkg::*;

  // ------------
  // Elaboration check
  // ------------
  if (NWORDS != 16)
  begin : g_bad_nwords
    $error("rsh_top: NWORDS must be 16");
  end

  // ------------
  // State
  // ------------
  logic [31:0]          ctrl_reg;        // Firmware control
  logic [`RSH_EV_W-1:0] ist_reg;         // Sticky events
  logic [`RSH_EV_W-1:0] imask_reg;       // Event mask
  rsh_words_type        link_in_reg;     // Link area +36..+51
  rsh_words_type        link_out_reg;    // Link area +20..+35
  rsh_words_type        resp_reg;        // Command response words
  rsh_words_type        sys_reg;         // System data words
  logic [15:0][15:0]    map_reg;         // Monitor and write indices
  logic [15:0]          err_code_reg;    // Last command error code
  logic                 resp_err_reg;    // Last command erred
  rsh_ry_type           ry_q_reg;        // Master flags, last cycle
  rsh_rx_type           rx_reg;          // Flags to master
  rsh_words_type        rwr_reg;         // Words to master
  logic [7:0]           tag_reg;         // Tag code
  logic [11:0]          wr_base_reg;     // Outgoing base
  logic [11:0]          rd_base_reg;     // Incoming base
  logic                 irq_reg;         // Interrupt
  logic                 pready_reg;      // Bus ready
  logic                 pslverr_reg;     // Bus error
  logic [31:0]          prdata_reg;      // Bus read data

  // ------------
  // Bus decode
  // ------------
  wire        acc      = psel & penable;               // Access phase
  wire        done     = acc & pready_reg;             // Completing edge
  wire        wr_en    = done & pwrite;                // Write takes effect
  wire [3:0]  widx     = paddr[5:2];                   // Word in window
  wire [11:0] win_base = paddr & ~(`RSH_WIN_SPAN - 12'h001);
  wire        hit_ctrl = (paddr == `RSH_OFF_CTRL);
  wire        hit_act  = (paddr == `RSH_OFF_ACTION);
  wire        hit_stat = (paddr == `RSH_OFF_STATUS);
  wire        hit_ist  = (paddr == `RSH_OFF_IRQ_STAT);
  wire        hit_imsk = (paddr == `RSH_OFF_IRQ_MASK);
  wire        hit_base = (paddr == `RSH_OFF_BASE);
  wire        hit_lin  = (win_base == `RSH_OFF_LINK_IN);
  wire        hit_lout = (win_base == `RSH_OFF_LINK_OUT);
  wire        hit_resp = (win_base == `RSH_OFF_RESP);
  wire        hit_sys  = (win_base == `RSH_OFF_SYSDATA);
  wire        hit_map  = (win_base == `RSH_OFF_MAP);
  wire        aligned  = (paddr[1:0] == 2'b00);
  wire        mapped   = aligned & (hit_ctrl | hit_act | hit_stat | hit_ist | hit_imsk
                         | hit_base | hit_lin | hit_lout | hit_resp | hit_sys | hit_map);
  wire [31:0] bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Firmware actions, one cycle each
  wire        act_cmd  = wr_en & hit_act & pwdata[`RSH_ACT_CMD_FIN];
  wire        act_init = wr_en & hit_act & pwdata[`RSH_ACT_INIT_FIN];
  wire        act_err  = wr_en & hit_act & pwdata[`RSH_ACT_ERR];
  wire [15:0] act_code = pwdata[`RSH_ACT_CODE_HI:`RSH_ACT_CODE_LO];

  // ------------
  // Control fields
  // ------------
  wire       os_up    = ctrl_reg[`RSH_CTRL_OS];
  wire       online   = ctrl_reg[`RSH_CTRL_ONLINE];
  wire       init_ent = ctrl_reg[`RSH_CTRL_INIT];
  wire       cmd_mode = ctrl_reg[`RSH_CTRL_CMDMODE];
  wire [4:0] pw_cnt   = ctrl_reg[`RSH_CTRL_PWC_HI:`RSH_CTRL_PWC_LO];

  // ------------
  // Master flag edges
  // ------------
  wire cmd_rise  = ry.cmd_req  & ~ry_q_reg.cmd_req;
  wire init_rise = ry.init_req & ~ry_q_reg.init_req;
  wire mon_rise  = ry.mon_req  & ~ry_q_reg.mon_req;
  wire rst_rise  = ry.err_rst  & ~ry_q_reg.err_rst;

  // Continuous read posted whose span covers the touch word
  wire [16:0] rd_first = {1'b0, rww[1]};
  wire [16:0] rd_last  = rd_first + {9'h000, rww[0][7:0]};
  wire        rd_cont  = (rww[0][15:8] == `RSH_CMD_CONT_READ);
  wire        rd_touch = cmd_rise & rd_cont
                         & (rd_first <= {13'h0000, `RSH_TOUCH_WORD})
                         & (rd_last  >  {13'h0000, `RSH_TOUCH_WORD});

  // Tag write into the touch word
  wire touch_wr = wr_en & hit_sys & (widx == `RSH_TOUCH_WORD);

  // ------------
  // Flag next values
  // ------------
  rsh_rx_type rx_next;
  always_comb
  begin
    rx_next = rx_reg;
    // Command complete follows finish, drops with the request
    if (!ry.cmd_req)
      rx_next.cmd_done = 1'b0;                                 // [RULE2]
    else if (act_cmd)
      rx_next.cmd_done = 1'b1;                                 // [RULE1] [RULE3]
    // Initial setting complete
    if (!ry.init_req)
      rx_next.init_done = 1'b0;                                // [RULE5]
    else if (act_init)
      rx_next.init_done = 1'b1;                                // [RULE4]
    // Error flag: a new error wins over the reset request
    if (act_err & cmd_mode)
      rx_next.err = 1'b1;                                      // [RULE6]
    else if (ry.err_rst)
      rx_next.err = 1'b0;                                      // [RULE6]
    // Touch and tag request: a new tag write wins over the clear
    if (touch_wr)
    begin
      rx_next.touch_done = 1'b1;                               // [RULE10]
      rx_next.tag_req    = 1'b1;                               // [RULE11]
    end
    else if (rd_touch)
    begin
      rx_next.touch_done = 1'b0;                               // [RULE12]
      rx_next.tag_req    = 1'b0;                               // [RULE12]
    end
    // Ready only when started, online and not entering data
    rx_next.ready = os_up & online & ~init_ent;                // [RULE9] [RULE18]
  end

  // ------------
  // Outgoing words
  // ------------
  rsh_words_type rwr_next;
  always_comb
  begin
    rwr_next = link_out_reg;                                   // [RULE15]
    if (cmd_mode)
    begin
      if (ry.mon_req)
      begin
        for (int i = 0; i < 16; i++)
          rwr_next[i] = sys_reg[map_reg[i][`RSH_MAP_MON_HI:`RSH_MAP_MON_LO]]; // [RULE7]
      end
      else
      begin
        rwr_next = resp_reg;
        // First word carries the code only after a failed command
        if (resp_err_reg)
          rwr_next[0] = err_code_reg;                          // [RULE17]
      end
    end
  end

  // ------------
  // Read data mux
  // ------------
  wire [31:0] status_w = {18'h00000, rx_reg, 3'b000, ry};
  wire [31:0] base_w   = {4'h0, rd_base_reg, 4'h0, wr_base_reg};
  wire [31:0] rd_mux   =
    hit_ctrl ? ctrl_reg :
    hit_stat ? status_w :
    hit_ist  ? {27'h0000000, ist_reg} :
    hit_imsk ? {27'h0000000, imask_reg} :
    hit_base ? base_w :
    hit_lin  ? {16'h0000, link_in_reg[widx]} :
    hit_lout ? {16'h0000, link_out_reg[widx]} :
    hit_resp ? {16'h0000, resp_reg[widx]} :
    hit_sys  ? {16'h0000, sys_reg[widx]} :
    hit_map  ? {16'h0000, map_reg[widx]} : 32'h0000_0000;

  // Station base: station 1 at zero, step four words
  wire [11:0] st_off = {6'h00, station - 6'h01} * `RSH_BASE_STEP;  // [RULE16]

  // Events and interrupt
  wire [`RSH_EV_W-1:0] ev = {rd_touch & rx_reg.touch_done, mon_rise,
                             rst_rise, init_rise, cmd_rise};
  wire [`RSH_EV_W-1:0] ist_clr = (wr_en & hit_ist) ? pwdata[`RSH_EV_W-1:0]
                                                   : {`RSH_EV_W{1'b0}};
  wire [`RSH_EV_W-1:0] ist_next = ev | (ist_reg & ~ist_clr);

  // ------------
  // Bus slave: one wait state, then ready with data
  // ------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~mapped;              // Unmapped answers error
      prdata_reg  <= (acc & ~pready_reg & ~pwrite & mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  // ------------
  // Control, mask, events, error code
  // ------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg     <= `RSH_CTRL_RST;
      imask_reg    <= `RSH_MASK_RST;
      ist_reg      <= {`RSH_EV_W{1'b0}};
      err_code_reg <= 16'h0000;
      resp_err_reg <= 1'b0;
    end
    else
    begin
      if (wr_en & hit_ctrl)
        ctrl_reg <= (ctrl_reg & ~bmask) | (pwdata & bmask);
      if (wr_en & hit_imsk)
        imask_reg <= pwdata[`RSH_EV_W-1:0];
      ist_reg <= ist_next;                                     // Set wins over clear
      if (act_cmd)
      begin
        err_code_reg <= act_code;                              // [RULE17]
        resp_err_reg <= act_err;
      end
    end
  end

  // ------------
  // Master flags, flags out, bases, interrupt
  // ------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ry_q_reg    <= '0;
      rx_reg      <= '0;                                       // [RULE19]
      tag_reg     <= 8'h00;
      wr_base_reg <= 12'h000;
      rd_base_reg <= `RSH_RD_BASE;
      irq_reg     <= 1'b0;
    end
    else
    begin
      ry_q_reg    <= ry;
      rx_reg      <= rx_next;
      tag_reg     <= sys_reg[`RSH_TOUCH_WORD][7:0];            // [RULE13]
      wr_base_reg <= st_off;                                   // [RULE16]
      rd_base_reg <= `RSH_RD_BASE + st_off;                    // [RULE16]
      irq_reg     <= |(ist_next & imask_reg);
    end
  end

  // ------------
  // Word windows
  // ------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_in_reg  <= '0;
      link_out_reg <= '0;
      resp_reg     <= '0;
      map_reg      <= '0;
      rwr_reg      <= '0;
    end
    else
    begin
      if (!cmd_mode)
        link_in_reg <= rww;                                    // [RULE14]
      if (wr_en & hit_lout)
        link_out_reg[widx] <= pwdata[15:0];
      if (wr_en & hit_resp)
        resp_reg[widx] <= pwdata[15:0];
      if (wr_en & hit_map)
        map_reg[widx] <= pwdata[15:0];
      rwr_reg <= rwr_next;
    end
  end

  // ------------
  // System data: periodic writes, then firmware or tag writes
  // ------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sys_reg <= '0;
    else
    begin
      if (cmd_mode & ry.pwr_req)
      begin
        for (int i = 0; i < 16; i++)
          if (i < int'(pw_cnt))
            sys_reg[map_reg[i][`RSH_MAP_PW_HI:`RSH_MAP_PW_LO]] <= rww[i]; // [RULE8]
      end
      if (wr_en & hit_sys)
        sys_reg[widx] <= pwdata[15:0];                         // [RULE10]
    end
  end

  // ------------
  // Outputs
  // ------------
  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign rx       = rx_reg;
  assign rwr      = rwr_reg;
  assign tag_code = tag_reg;
  assign wr_base  = wr_base_reg;
  assign rd_base  = rd_base_reg;
  assign irq      = irq_reg;

endmodule

// ---- testbench/rsh_master_model.sv ----
/*
  Master station model: drives request flags and remote words.
  Assumes pclk and the device flags of the block under test.
*/
`timescale 1ns/100ps
module rsh_master_model (
  input  wire logic                  pclk, // Clock
  input  wire rsh_pkg::rsh_rx_type   rx,   // Flags from device
  output rsh_pkg::rsh_ry_type        ry,   // Flags to device
  output rsh_pkg::rsh_words_type     rww   // Words to device
);
  import rsh_pkg::*;
  // Quiet start
  initial ry = '0;
  initial rww = '0;
  // Drop a command request only once completion is seen
  always @(posedge pclk)
    if (ry.cmd_req && rx.cmd_done)
      ry.cmd_req <= 1'h0;
  // Post a command: words first, request one edge later
  task post(input logic [15:0] w0, input logic [15:0] w1);
    @(posedge pclk);
    rww[0] <= w0;
    rww[1] <= w1;
    @(posedge pclk);
    ry.cmd_req <= 1'h1;
  endtask
  // Set one request flag
  task setf(input int i, input logic v);
    @(posedge pclk);
    ry[i] <= v;
  endtask
  // Set one outgoing word
  task word(input int i, input logic [15:0] v);
    @(posedge pclk);
    rww[i] <= v;
  endtask
endmodule

// ---- testbench/rsh_top_checker.sv ----
/*
  Port assertions for the remote station handshake block.
  Assumes one clock pclk and async active-low presetn.
*/
`timescale 1ns/100ps
module rsh_top_checker #(
  parameter int NWORDS = 16 // Remote words per direction
) (
  input wire logic                   pclk,     // Clock
  input wire logic                   presetn,  // Reset, active low
  input wire logic                   psel,     // APB select
  input wire logic                   penable,  // APB access
  input wire logic                   pwrite,   // APB write
  input wire logic [11:0]            paddr,    // APB address
  input wire logic [31:0]            pwdata,   // APB write data
  input wire logic [3:0]             pstrb,    // APB strobes
  input wire logic [31:0]            prdata,   // APB read data
  input wire logic                   pready,   // APB ready
  input wire logic                   pslverr,  // APB error
  input wire rsh_pkg::rsh_ry_type    ry,       // Master flags
  input wire rsh_pkg::rsh_words_type rww,      // Master words
  input wire logic [5:0]             station,  // Station number
  input wire rsh_pkg::rsh_rx_type    rx,       // Device flags
  input wire rsh_pkg::rsh_words_type rwr,      // Device words
  input wire logic [7:0]             tag_code, // Tag code
  input wire logic [11:0]            wr_base,  // Outgoing base
  input wire logic [11:0]            rd_base,  // Incoming base
  input wire logic                   irq       // Interrupt
);
  import rsh_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completing writes and a read command that spans word 13
  wire logic        acc = psel && penable && pready && pwrite; // Write lands
  wire logic        act = acc && paddr == 12'h004;             // Action write
  wire logic        tch = acc && paddr == 12'h134;             // Touch word write
  wire logic [16:0] lst = {1'h0, rww[1]} + {9'h000, rww[0][7:0]}; // End of read
  wire logic        r13 = rww[0][15:8] == 8'h02 && rww[1] <= 16'h000d && lst > 17'h0000d;
  AST_CMD_SET:
    assert property (act && pwdata[0] && ry.cmd_req |=> rx.cmd_done) else $error("no cmd_done");
  AST_CMD_CLR:
    assert property (!ry.cmd_req |=> !rx.cmd_done) else $error("cmd_done held");
  AST_INIT_SET:
    assert property (act && pwdata[1] && ry.init_req |=> rx.init_done) else $error("no init");
  AST_INIT_CLR:
    assert property (!ry.init_req |=> !rx.init_done) else $error("init_done held");
  AST_ERR_CLR:
    assert property (ry.err_rst && !(act && pwdata[2]) |=> !rx.err) else $error("err held");
  AST_TOUCH_SET:
    assert property (tch |=> rx.touch_done && rx.tag_req) else $error("no touch flag");
  AST_TAG_PAIR:
    assert property (rx.tag_req == rx.touch_done) else $error("tag_req differs");
  AST_TOUCH_CLR:
    assert property ($rose(ry.cmd_req) && r13 && !tch |=> !rx.touch_done) else $error("touch held");
  AST_BASE:
    assert property ($stable(station) |=> wr_base == ({6'h00, $past(station)} - 12'h001) * 12'h004
      && rd_base == 12'h100 + wr_base) else $error("bad base");
  // Main scenarios reached
  cover property (act && pwdata[0] && ry.cmd_req);
  cover property ($rose(rx.touch_done));
  cover property ($fell(rx.err));
endmodule
bind rsh_top rsh_top_checker #(.NWORDS(NWORDS)) rsh_top_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ry(ry), .rww(rww), .station(station), .rx(rx), .rwr(rwr),
  .tag_code(tag_code), .wr_base(wr_base), .rd_base(rd_base), .irq(irq));

// ---- testbench/rsh_top_test.sv ----
/*
  Self-checking bench: APB register access plus a master model.
  Assumes a 125 MHz pclk and the checker bound into rsh_top.
*/
`timescale 1ns/100ps
module rsh_top_test;
  import rsh_pkg::*;
  logic          pclk = 1'h0;    // Clock
  logic          presetn = 1'h0; // Reset, active low
  logic          psel = 1'h0;    // APB select
  logic          penable = 1'h0; // APB access
  logic          pwrite = 1'h0;  // APB write
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, q;      // Read data, last read
  logic          pready, pslverr, irq, serr;
  logic [5:0]    station = 6'h01;
  logic [7:0]    tag_code;
  logic [11:0]   wr_base, rd_base;
  rsh_ry_type    ry;             // Master flags
  rsh_rx_type    rx;             // Device flags
  rsh_words_type rww, rwr;       // Word windows
  int            miscompares = 0;
  int            n_checks = 0;
  wire logic [7:0] obs = {ry.cmd_req, irq, rx}; // Watched flags
  always #4 pclk = ~pclk;
  rsh_top rsh_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ry(ry), .rww(rww), .station(station), .rx(rx),
    .rwr(rwr), .tag_code(tag_code), .wr_base(wr_base), .rd_base(rd_base), .irq(irq));
  rsh_master_model rsh_master_model_inst (.pclk(pclk), .rx(rx), .ry(ry), .rww(rww));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bounded wait for a watched flag, then judge it
  task waitv(input string n, input int i, input logic v);
    for (int k = 0; k < 40 && obs[i] !== v; k++)
      @(posedge pclk);
    chk(n, {31'h0, v}, {31'h0, obs[i]});
    if (obs[i] !== v)
      print_verdict();
  endtask
  // One APB transfer; setup, access, hold until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    for (k = 0; pready !== 1'h1 && k < 20; k++)
      @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 20)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task rd(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task fin(input logic [31:0] d);
    wr(12'h004, d);
    waitv("cmd_req", 7, 1'h0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk("flags", 32'h0, {24'h0, obs});
    chk("rd_base", 32'h100, {20'h0, rd_base});
  endtask
  task t_ready;
    wr(12'h000, 32'h3); waitv("ready", 5, 1'h1);
    wr(12'h000, 32'h7); waitv("ready", 5, 1'h0);
    wr(12'h000, 32'h3); waitv("ready", 5, 1'h1);
    wr(12'h000, 32'h1); waitv("ready", 5, 1'h0);
    wr(12'h000, 32'hb); waitv("ready", 5, 1'h1);
  endtask
  task t_cmd;
    wr(12'h010, 32'h1f); // Enable every event
    rsh_master_model_inst.post(16'h0400, 16'h0000);
    waitv("irq", 6, 1'h1);
    chk("early done", 32'h0, {31'h0, obs[0]});
    wr(12'h004, 32'h1); waitv("cmd_done", 0, 1'h1);
    waitv("cmd_done", 0, 1'h0);
    rd(12'h00c); chk("irq_stat", 32'h1, q);
    wr(12'h00c, 32'h1f); waitv("irq", 6, 1'h0);
    wr(12'h010, 32'h0); // Mask every event
  endtask
  task t_err;
    wr(12'h0c0, 32'h5a5a);
    rsh_master_model_inst.post(16'h0400, 16'h0000);
    rd(12'h00c); chk("irq_stat", 32'h1, q);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(12'h004, 32'h0123_0005); waitv("err", 4, 1'h1);
    waitv("cmd_req", 7, 1'h0);
    chk("resp0", 32'h0123, {16'h0, rwr[0]});
    rsh_master_model_inst.setf(4, 1'h1); waitv("err", 4, 1'h0);
    rsh_master_model_inst.setf(4, 1'h0);
    rsh_master_model_inst.post(16'h0400, 16'h0000);
    fin(32'h1);
    chk("resp0", 32'h5a5a, {16'h0, rwr[0]});
  endtask
  task t_init;
    rsh_master_model_inst.setf(3, 1'h1);
    wr(12'h004, 32'h2); waitv("init_done", 3, 1'h1);
    rsh_master_model_inst.setf(3, 1'h0); waitv("init_done", 3, 1'h0);
  endtask
  task t_touch;
    wr(12'h134, 32'h00a7); waitv("touch_done", 1, 1'h1);
    chk("tag_req", 32'h1, {31'h0, obs[2]});
    @(posedge pclk);
    chk("tag_code", 32'ha7, {24'h0, tag_code});
    rsh_master_model_inst.post(16'h0202, 16'h000e);
    fin(32'h1);
    chk("touch kept", 32'h1, {31'h0, obs[1]});
    rsh_master_model_inst.post(16'h0202, 16'h000c);
    waitv("touch_done", 1, 1'h0);
    chk("tag_req", 32'h0, {31'h0, obs[2]});
    fin(32'h1);
  endtask
  task t_mon;
    wr(12'h140, 32'h050d); wr(12'h144, 32'h3); wr(12'h10c, 32'h1111);
    rsh_master_model_inst.setf(1, 1'h1);
    repeat (3) @(posedge pclk);
    chk("mon0", 32'ha7, {16'h0, rwr[0]});
    chk("mon1", 32'h1111, {16'h0, rwr[1]});
    rsh_master_model_inst.setf(1, 1'h0);
  endtask
  task t_pwr;
    wr(12'h000, 32'h1b); rsh_master_model_inst.word(0, 16'hbeef);
    rsh_master_model_inst.setf(2, 1'h1);
    repeat (3) @(posedge pclk);
    rd(12'h114); chk("sys5", 32'hbeef, q);
    rsh_master_model_inst.word(0, 16'hcafe);
    repeat (3) @(posedge pclk);
    rd(12'h114); chk("sys5", 32'hcafe, q);
    rsh_master_model_inst.setf(2, 1'h0);
    wr(12'h000, 32'h3);
  endtask
  task t_ord;
    rsh_master_model_inst.word(15, 16'h1234);
    repeat (3) @(posedge pclk);
    rd(12'h07c); chk("link_in15", 32'h1234, q);
    wr(12'h090, 32'h4321);
    repeat (2) @(posedge pclk);
    chk("rwr4", 32'h4321, {16'h0, rwr[4]});
    rd(12'h1fc); chk("slverr", 32'h1, {31'h0, serr});
  endtask
  task t_base;
    station <= 6'h03;
    repeat (3) @(posedge pclk);
    chk("wr_base", 32'h8, {20'h0, wr_base});
    rd(12'h014); chk("base", 32'h0108_0008, q);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset;
    t_ready;
    t_cmd;
    t_err;
    t_init;
    t_touch;
    t_mon;
    t_pwr;
    t_ord;
    t_base;
    print_verdict();
  end
endmodule
